// [bench/modem_cfg_properties.sv]
// port assertions for the modem configuration bank
`timescale 1ns/1ns
module modem_cfg_properties
  import modem_cfg_pkg::*;
(
  // clock, reset and register port
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // modem side
  input wire logic BAND_UPPER,
  input wire logic FILTER_TICK,
  input wire logic GAUSSIAN_SHAPING,
  input wire logic OOK_MODE,
  input wire logic [TX_DEV_SCALE_W-1:0] TX_DEV_SCALE,
  input wire logic AFC_ENABLE,
  input wire logic [AFC_PAIRS_W-1:0] AFC_AVERAGE_PAIRS,
  input wire logic [RX_DEV_SCALE_W-1:0] RX_DEV_SCALE,
  input wire logic FILTER_BYPASS,
  input wire logic [DECIMATOR_INPUT_SHIFT_W-1:0] DECIMATOR_INPUT_SHIFT,
  input wire logic [DIVISOR_W-1:0] DECIMATION_DIVISOR,
  input wire logic [CHANNEL_BW_W-1:0] CHANNEL_BW_HZ,
  input wire logic DECIMATION_TICK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic w_tx;
  logic w_afc;
  logic w_flt;
  assign w_tx = WR && ADDR == TX_DEVIATION_CONFIG_ADDR;
  assign w_afc = WR && ADDR == AFC_RX_DEVIATION_CONFIG_ADDR;
  assign w_flt = WR && ADDR == CHANNEL_FILTER_CONFIG_ADDR;
  // ----------------------------------------
  // decoded controls follow each write
  // ----------------------------------------
  shaping_bit_a: assert property (w_tx |=> GAUSSIAN_SHAPING == $past(WDATA[7]))
    else $error("shaping bit not applied");
  // band held across the write, so the band offset is unambiguous
  tx_scale_a: assert property (w_tx && $stable(BAND_UPPER) |=> TX_DEV_SCALE ==
    (12'($past(WDATA[3:0])) << ({1'b0, $past(WDATA[6:4])} + {3'h0, $past(BAND_UPPER)})))
    else $error("tx deviation scale wrong");
  ook_select_a: assert property (w_tx |=> OOK_MODE == ($past(WDATA[3:0]) == 4'h0))
    else $error("ook selection wrong");
  afc_mode_a: assert property (w_afc |=> AFC_ENABLE == ($past(WDATA[7:6]) != 2'h0) && AFC_AVERAGE_PAIRS ==
    (($past(WDATA[7:6]) == 2'h3) ? 3'h4 : 3'($past(WDATA[7:6]))))
    else $error("afc averaging wrong");
  rx_scale_a: assert property (w_afc |=> RX_DEV_SCALE == (7'($past(WDATA[3:0])) << $past(WDATA[5:4])))
    else $error("rx deviation scale wrong");
  bypass_shift_a: assert property (w_flt |=> FILTER_BYPASS == $past(WDATA[7]) &&
    DECIMATOR_INPUT_SHIFT == $past(WDATA[6:5]))
    else $error("bypass or shift wrong");
  divisor_value_a: assert property (w_flt |=> DECIMATION_DIVISOR == $past(WDATA[4:0]) + 6'h01)
    else $error("decimation divisor wrong");
  divide_by_one_a: assert property ($past(DECIMATION_DIVISOR) == 6'h01 && DECIMATION_DIVISOR == 6'h01 &&
    FILTER_TICK |=> DECIMATION_TICK)
    else $error("tick missing at divisor one");
  channel_bw_a: assert property (w_flt |=> CHANNEL_BW_HZ ==
    19'(CHANNEL_BW_FULL_HZ / ($past(WDATA[4:0]) + 1)))
    else $error("channel bandwidth wrong");
  // ----------------------------------------
  // register port
  // ----------------------------------------
  read_back_a: assert property (w_tx ##1 RD && ADDR == TX_DEVIATION_CONFIG_ADDR |=> RDATA == $past(WDATA, 2))
    else $error("read after write stale");
  rdata_quiet_a: assert property (!RD || !(ADDR inside {8'h0e, 8'h0f, 8'h10}) |=> RDATA == 8'h00)
    else $error("read data not quiet");
  cover property (w_tx ##1 RD);
  cover property (w_flt ##1 FILTER_TICK);
  cover property (DECIMATION_TICK);
endmodule

bind modem_deviation_afc_filter_config modem_cfg_properties u_props (
  .CLK_SYS, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .BAND_UPPER, .FILTER_TICK,
  .GAUSSIAN_SHAPING, .OOK_MODE, .TX_DEV_SCALE, .AFC_ENABLE, .AFC_AVERAGE_PAIRS, .RX_DEV_SCALE,
  .FILTER_BYPASS, .DECIMATOR_INPUT_SHIFT, .DECIMATION_DIVISOR, .CHANNEL_BW_HZ, .DECIMATION_TICK
);

// [bench/tb_modem_deviation_afc_filter_config.sv]
// self-checking bench for the modem configuration bank
`timescale 1ns/1ns
module tb_modem_deviation_afc_filter_config;
  import modem_cfg_pkg::*;
  logic CLK_SYS = 0, RST_N = 0, WR = 0, RD = 0, BAND_UPPER = 0, FILTER_TICK = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic GAUSSIAN_SHAPING, OOK_MODE, AFC_ENABLE, FILTER_BYPASS, DECIMATION_TICK;
  logic [TX_DEV_SCALE_W-1:0] TX_DEV_SCALE;
  logic [AFC_PAIRS_W-1:0] AFC_AVERAGE_PAIRS;
  logic [RX_DEV_SCALE_W-1:0] RX_DEV_SCALE;
  logic [DECIMATOR_INPUT_SHIFT_W-1:0] DECIMATOR_INPUT_SHIFT;
  logic [DIVISOR_W-1:0] DECIMATION_DIVISOR;
  logic [CHANNEL_BW_W-1:0] CHANNEL_BW_HZ;
  int bad_count = 0;
  int total_checks = 0;
  modem_deviation_afc_filter_config DUT (
    .CLK_SYS, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .BAND_UPPER, .FILTER_TICK,
    .GAUSSIAN_SHAPING, .OOK_MODE, .TX_DEV_SCALE, .AFC_ENABLE, .AFC_AVERAGE_PAIRS, .RX_DEV_SCALE,
    .FILTER_BYPASS, .DECIMATOR_INPUT_SHIFT, .DECIMATION_DIVISOR, .CHANNEL_BW_HZ, .DECIMATION_TICK
  );
  initial begin
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // strobes change only right after an edge, never twice in one step
  task automatic req(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req(1'b1, 1'b0, a, d);
    req(1'b0, 1'b0, a, 8'h00);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    req(1'b0, 1'b1, a, 8'h00);
    req(1'b0, 1'b0, a, 8'h00);
    #1;
    chk(RDATA, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(8'h0e, 8'he8);
    rd_chk(8'h0f, 8'h9c);
    rd_chk(8'h10, 8'h00);
    chk(GAUSSIAN_SHAPING, 1);
    chk(TX_DEV_SCALE, 8 << 6);
    chk(AFC_AVERAGE_PAIRS, 2);
    chk(RX_DEV_SCALE, 12 << 1);
    chk(CHANNEL_BW_HZ, 307200);
  endtask
  task automatic t_tx;
    wr(8'h0e, 8'h7f);
    chk(GAUSSIAN_SHAPING, 0);
    chk(OOK_MODE, 0);
    chk(TX_DEV_SCALE, 15 << 7);
    BAND_UPPER <= 1'b1;
    wr(8'h0e, 8'h7f);
    chk(TX_DEV_SCALE, 15 << 8);
    wr(8'h0e, 8'hb0);
    chk(OOK_MODE, 1);
    chk(GAUSSIAN_SHAPING, 1);
    BAND_UPPER <= 1'b0;
  endtask
  task automatic t_afc;
    for (int i = 0; i < 4; i++) begin
      wr(8'h0f, {i[1:0], 6'h3f});
      chk(AFC_ENABLE, i != 0);
      chk(AFC_AVERAGE_PAIRS, i == 3 ? 4 : i);
      chk(RX_DEV_SCALE, 15 << 3);
    end
    // rx deviation mantissa 8, exponent 0, while the last tx setting still selects on-off keying
    wr(8'h0f, 8'h08);
    chk(RX_DEV_SCALE, 8);
  endtask
  task automatic t_filter;
    wr(8'h10, 8'hff);
    chk(FILTER_BYPASS, 1);
    chk(DECIMATOR_INPUT_SHIFT, 3);
    chk(DECIMATION_DIVISOR, 32);
    chk(CHANNEL_BW_HZ, 9600);
    req(1'b1, 1'b0, 8'h10, 8'h5e);
    rd_chk(8'h10, 8'h5e);
    chk(FILTER_BYPASS, 0);
    chk(DECIMATOR_INPUT_SHIFT, 2);
    chk(CHANNEL_BW_HZ, 307200 / 31);
    req(1'b1, 1'b0, 8'h0e, 8'h4a);
    rd_chk(8'h0e, 8'h4a);
    wr(8'h11, 8'haa);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h10, 8'h5e);
  endtask
  // six back-to-back filter ticks per divisor setting
  task automatic t_decim;
    int cnt;
    for (int s = 0; s < 3; s += 2) begin
      wr(8'h10, 8'(s));
      cnt = 0;
      for (int n = 0; n < 9; n++) begin
        @(posedge CLK_SYS);
        FILTER_TICK <= (n < 6);
        #1;
        if (DECIMATION_TICK === 1'b1) cnt++;
      end
      chk(cnt, 6 / (s + 1));
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    t_reset();
    t_tx();
    t_afc();
    t_filter();
    t_decim();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    bad_count++;
    give_verdict();
  end
endmodule

// [design/decimation_clock_divider.sv]
// decimation clock divider: one pulse per (select + 1) filter clock ticks
`timescale 1ns/1ns
module decimation_clock_divider
  import modem_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to the configuration bank
  decimation_link_if.div link
);
  logic [DECIMATION_DIVISOR_SELECT_W-1:0] count;
  logic [DECIMATION_DIVISOR_SELECT_W-1:0] next_count;
  logic tick;
  logic next_tick;

  // ----------------------------------------
  // divide by select plus one
  // ----------------------------------------
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (link.filter_tick) begin
      // a shrunk select must not strand the counter above it
      if (count >= link.divisor_select) begin
        next_count = '0;
        next_tick = 1'b1;
      end else begin
        next_count = count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign link.decimation_tick = tick;
endmodule

// [design/decimation_link_if.sv]
// carrier between the configuration bank and the decimation clock divider
`timescale 1ns/1ns
interface decimation_link_if;
  import modem_cfg_pkg::*;
  logic [DECIMATION_DIVISOR_SELECT_W-1:0] divisor_select;
  logic filter_tick;
  logic decimation_tick;
  modport cfg (output divisor_select, output filter_tick, input decimation_tick);
  modport div (input divisor_select, input filter_tick, output decimation_tick);
endinterface

// [design/modem_cfg_pkg.sv]
// constants and types for the modem deviation, afc and filter configuration bank
package modem_cfg_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] TX_DEVIATION_CONFIG_ADDR = 8'h0e;
  localparam logic [7:0] AFC_RX_DEVIATION_CONFIG_ADDR = 8'h0f;
  localparam logic [7:0] CHANNEL_FILTER_CONFIG_ADDR = 8'h10;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] TX_DEVIATION_CONFIG_RESET = 8'he8;
  localparam logic [7:0] AFC_RX_DEVIATION_CONFIG_RESET = 8'h9c;
  localparam logic [7:0] CHANNEL_FILTER_CONFIG_RESET = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TX_SHAPING_BIT = 7;
  localparam int TX_EXP_LSB = 4;
  localparam int TX_EXP_W = 3;
  localparam int TX_MANT_LSB = 0;
  localparam int TX_MANT_W = 4;
  localparam int AFC_AVG_LSB = 6;
  localparam int AFC_AVG_W = 2;
  localparam int RX_EXP_LSB = 4;
  localparam int RX_EXP_W = 2;
  localparam int RX_MANT_LSB = 0;
  localparam int RX_MANT_W = 4;
  localparam int FILTER_BYPASS_BIT = 7;
  localparam int DECIMATOR_INPUT_SHIFT_LSB = 5;
  localparam int DECIMATOR_INPUT_SHIFT_W = 2;
  localparam int DECIMATION_DIVISOR_SELECT_LSB = 0;
  localparam int DECIMATION_DIVISOR_SELECT_W = 5;

  // ----------------------------------------
  // deviation and bandwidth scaling
  // ----------------------------------------
  localparam int TX_DEV_SCALE_W = 12;
  localparam int TX_DEV_LOWER_BAND_EXP_OFFSET = 16;
  localparam int TX_DEV_UPPER_BAND_EXP_OFFSET = 15;
  localparam int RX_DEV_SCALE_W = 7;
  localparam int RX_DEV_EXP_OFFSET = 3;
  localparam int RX_DEV_DIVISOR = 3;
  localparam int CHANNEL_BW_FULL_HZ = 307200;
  localparam int CHANNEL_BW_W = 19;
  localparam int DIVISOR_W = 6;
  localparam int AFC_PAIRS_W = 3;

  // ----------------------------------------
  // afc averaging modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    AFC_OFF = 2'h0,
    AFC_ONE_PAIR = 2'h1,
    AFC_TWO_PAIRS = 2'h2,
    AFC_FOUR_PAIRS = 2'h3
  } afc_mode_t;
endpackage

// [design/modem_deviation_afc_filter_config.sv]
// modem deviation, afc and channel filter configuration bank
//
// What this block does
// - shaping bit set enables gaussian transmit shaping
// - tx deviation scale mantissa times two-power of exponent plus upper-band bit
// - zero tx mantissa selects on-off keying
// - afc field: off, or 1/2/4 pair averaging
// - rx deviation scale from mantissa and exponent
// - bypass bit routes around anti-alias filter
// - decimator input shifted by shift field bits
// - decimation divisor equals field value plus one
// - channel bandwidth is 307.2 kHz over divisor
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module modem_deviation_afc_filter_config
  import modem_cfg_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // band and timing inputs
  input wire logic BAND_UPPER,
  input wire logic FILTER_TICK,
  // transmit modulation controls
  output logic GAUSSIAN_SHAPING,
  output logic OOK_MODE,
  output logic [TX_DEV_SCALE_W-1:0] TX_DEV_SCALE,
  // receive demodulation controls
  output logic AFC_ENABLE,
  output logic [AFC_PAIRS_W-1:0] AFC_AVERAGE_PAIRS,
  output logic [RX_DEV_SCALE_W-1:0] RX_DEV_SCALE,
  // channel filter controls
  output logic FILTER_BYPASS,
  output logic [DECIMATOR_INPUT_SHIFT_W-1:0] DECIMATOR_INPUT_SHIFT,
  output logic [DIVISOR_W-1:0] DECIMATION_DIVISOR,
  output logic [CHANNEL_BW_W-1:0] CHANNEL_BW_HZ,
  output logic DECIMATION_TICK
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [AFC_PAIRS_W-1:0] afc_pairs(input logic [AFC_AVG_W-1:0] mode);
    unique case (afc_mode_t'(mode))
      AFC_OFF: afc_pairs = 3'h0;
      AFC_ONE_PAIR: afc_pairs = 3'h1;
      AFC_TWO_PAIRS: afc_pairs = 3'h2;
      AFC_FOUR_PAIRS: afc_pairs = 3'h4;
    endcase
  endfunction

  function automatic logic [CHANNEL_BW_W-1:0] channel_bw(input logic [DIVISOR_W-1:0] divisor);
    logic [31:0] bw;
    bw = CHANNEL_BW_FULL_HZ / {26'h0, divisor};
    channel_bw = bw[CHANNEL_BW_W-1:0];
  endfunction

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] tx_deviation_config;
  logic [7:0] afc_rx_deviation_config;
  logic [7:0] channel_filter_config;
  logic [7:0] next_tx_deviation_config;
  logic [7:0] next_afc_rx_deviation_config;
  logic [7:0] next_channel_filter_config;
  logic [7:0] next_rdata;

  always_comb begin
    next_tx_deviation_config = tx_deviation_config;
    next_afc_rx_deviation_config = afc_rx_deviation_config;
    next_channel_filter_config = channel_filter_config;
    if (WR) begin
      unique case (ADDR)
        TX_DEVIATION_CONFIG_ADDR: next_tx_deviation_config = WDATA;
        AFC_RX_DEVIATION_CONFIG_ADDR: next_afc_rx_deviation_config = WDATA;
        CHANNEL_FILTER_CONFIG_ADDR: next_channel_filter_config = WDATA;
        default: ;
      endcase
    end
  end

  // unmapped reads answer zero; data stands for one cycle only
  always_comb begin
    next_rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        TX_DEVIATION_CONFIG_ADDR: next_rdata = tx_deviation_config;
        AFC_RX_DEVIATION_CONFIG_ADDR: next_rdata = afc_rx_deviation_config;
        CHANNEL_FILTER_CONFIG_ADDR: next_rdata = channel_filter_config;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_deviation_config <= TX_DEVIATION_CONFIG_RESET;
      afc_rx_deviation_config <= AFC_RX_DEVIATION_CONFIG_RESET;
      channel_filter_config <= CHANNEL_FILTER_CONFIG_RESET;
      RDATA <= 8'h00;
    end else begin
      tx_deviation_config <= next_tx_deviation_config;
      afc_rx_deviation_config <= next_afc_rx_deviation_config;
      channel_filter_config <= next_channel_filter_config;
      RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  // decoded from the next register values so a write reaches the
  // registered controls at the same edge that stores it; the divider sees it one edge later
  logic [TX_EXP_W-1:0] tx_deviation_exponent;
  logic [TX_MANT_W-1:0] tx_deviation_mantissa;
  logic [AFC_AVG_W-1:0] afc_average_mode;
  logic [RX_EXP_W-1:0] rx_deviation_exponent;
  logic [RX_MANT_W-1:0] rx_deviation_mantissa;
  logic [DECIMATOR_INPUT_SHIFT_W-1:0] decimator_input_shift;
  logic [DECIMATION_DIVISOR_SELECT_W-1:0] decimation_divisor_select;

  assign tx_deviation_exponent = next_tx_deviation_config[TX_EXP_LSB +: TX_EXP_W];
  assign tx_deviation_mantissa = next_tx_deviation_config[TX_MANT_LSB +: TX_MANT_W];
  assign afc_average_mode = next_afc_rx_deviation_config[AFC_AVG_LSB +: AFC_AVG_W];
  assign rx_deviation_exponent = next_afc_rx_deviation_config[RX_EXP_LSB +: RX_EXP_W];
  assign rx_deviation_mantissa = next_afc_rx_deviation_config[RX_MANT_LSB +: RX_MANT_W];
  assign decimator_input_shift = next_channel_filter_config[DECIMATOR_INPUT_SHIFT_LSB +: DECIMATOR_INPUT_SHIFT_W];
  assign decimation_divisor_select = next_channel_filter_config[DECIMATION_DIVISOR_SELECT_LSB +: DECIMATION_DIVISOR_SELECT_W];

  // ----------------------------------------
  // modem controls
  // ----------------------------------------
  logic next_gaussian_shaping;
  logic next_ook_mode;
  logic [TX_DEV_SCALE_W-1:0] next_tx_dev_scale;
  logic next_afc_enable;
  logic [AFC_PAIRS_W-1:0] next_afc_average_pairs;
  logic [RX_DEV_SCALE_W-1:0] next_rx_dev_scale;
  logic next_filter_bypass;
  logic [DECIMATOR_INPUT_SHIFT_W-1:0] next_decimator_input_shift;
  logic [DIVISOR_W-1:0] next_decimation_divisor;
  logic [CHANNEL_BW_W-1:0] next_channel_bw_hz;

  always_comb begin
    next_gaussian_shaping = next_tx_deviation_config[TX_SHAPING_BIT];
    next_ook_mode = (tx_deviation_mantissa == 4'h0);
    // deviation = fref * scale / 2^16; the upper band doubles it, i.e. 2^-15
    next_tx_dev_scale = {8'h00, tx_deviation_mantissa}
      << ({1'b0, tx_deviation_exponent} + {3'h0, BAND_UPPER});
    next_afc_enable = (afc_average_mode != AFC_OFF);
    next_afc_average_pairs = afc_pairs(afc_average_mode);
    // expected deviation = baud * scale / 2^3 / 3, applied by the demodulator
    next_rx_dev_scale = {3'h0, rx_deviation_mantissa} << rx_deviation_exponent;
    next_filter_bypass = next_channel_filter_config[FILTER_BYPASS_BIT];
    next_decimator_input_shift = decimator_input_shift;
    next_decimation_divisor = {1'b0, decimation_divisor_select} + 6'h01;
    next_channel_bw_hz = channel_bw(next_decimation_divisor);
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      GAUSSIAN_SHAPING <= 1'b0;
      OOK_MODE <= 1'b0;
      TX_DEV_SCALE <= '0;
      AFC_ENABLE <= 1'b0;
      AFC_AVERAGE_PAIRS <= '0;
      RX_DEV_SCALE <= '0;
      FILTER_BYPASS <= 1'b0;
      DECIMATOR_INPUT_SHIFT <= '0;
      DECIMATION_DIVISOR <= '0;
      CHANNEL_BW_HZ <= '0;
    end else begin
      GAUSSIAN_SHAPING <= next_gaussian_shaping;
      OOK_MODE <= next_ook_mode;
      TX_DEV_SCALE <= next_tx_dev_scale;
      AFC_ENABLE <= next_afc_enable;
      AFC_AVERAGE_PAIRS <= next_afc_average_pairs;
      RX_DEV_SCALE <= next_rx_dev_scale;
      FILTER_BYPASS <= next_filter_bypass;
      DECIMATOR_INPUT_SHIFT <= next_decimator_input_shift;
      DECIMATION_DIVISOR <= next_decimation_divisor;
      CHANNEL_BW_HZ <= next_channel_bw_hz;
    end
  end

  // ----------------------------------------
  // decimation clock
  // ----------------------------------------
  decimation_link_if link ();

  assign link.divisor_select = channel_filter_config[DECIMATION_DIVISOR_SELECT_LSB +: DECIMATION_DIVISOR_SELECT_W];
  assign link.filter_tick = FILTER_TICK;

  decimation_clock_divider divider (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .link(link.div)
  );

  // pulse comes from the divider's own flop
  assign DECIMATION_TICK = link.decimation_tick;
endmodule
